// *** core/lcg3_cfg.svh ***
// Constants for the gate-three input selector of the logic cell
// How it works
// - Bit 7 gates data four true in
// - Bit 6 gates data four inverted in
// - Bit 2 gates data two inverted in
// - Bit 1 gates data one true in
// - Bit 0 gates data one inverted in
`ifndef LCG3_CFG_SVH
`define LCG3_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LCG3_OFF_SELECT 12'h000
`define LCG3_OFF_STATUS 12'h004
`define LCG3_ADDR_W 12

// ==========================================================
// Field positions inside the select register
`define LCG3_BIT_D4T 7
`define LCG3_BIT_D4N 6
`define LCG3_BIT_D3T 5
`define LCG3_BIT_D3N 4
`define LCG3_BIT_D2T 3
`define LCG3_BIT_D2N 2
`define LCG3_BIT_D1T 1
`define LCG3_BIT_D1N 0

// ==========================================================
// Field positions inside the status register
`define LCG3_STAT_TERM_LSB 0
`define LCG3_STAT_GATE_BIT 8

// ==========================================================
// Reset values
`define LCG3_RST_SELECT 8'h00
`define LCG3_RST_WORD 32'h0000_0000

`endif

// *** core/lcg3_pkg.sv ***
// Types shared by the gate-three input selector
package lcg3_pkg;

    // ==========================================================
    // Select register, one bit per candidate signal
    typedef struct packed {
        logic g3TakeData4True;
        logic g3TakeData4Inv;
        logic g3TakeData3True;
        logic g3TakeData3Inv;
        logic g3TakeData2True;
        logic g3TakeData2Inv;
        logic g3TakeData1True;
        logic g3TakeData1Inv;
    } lcg3_select_t;

    // ==========================================================
    // Register decode result
    typedef enum logic [1:0] {
        LCG3_REG_SELECT,
        LCG3_REG_STATUS,
        LCG3_REG_NONE
    } lcg3_reg_t;

endpackage

// *** core/lcg3_gate_mux.sv ***
// Masks the eight candidate signals and ORs the survivors into gate three
`timescale 1ns/1ps
`default_nettype none
`include "lcg3_cfg.svh"

module lcg3_gate_mux
    import lcg3_pkg::*;
(
    // Selection
    input wire lcg3_pkg::lcg3_select_t sel,
    // Data selector outputs, true form
    input wire logic data1In,
    input wire logic data2In,
    input wire logic data3In,
    input wire logic data4In,
    // Results
    output logic [7:0] termMask,
    output logic gateThreeInput
);
    logic data1TrueSig;
    logic data1InvSig;
    logic data2TrueSig;
    logic data2InvSig;
    logic data3TrueSig;
    logic data3InvSig;
    logic data4TrueSig;
    logic data4InvSig;

    assign data1TrueSig = data1In;
    assign data1InvSig = ~data1In;
    assign data2TrueSig = data2In;
    assign data2InvSig = ~data2In;
    assign data3TrueSig = data3In;
    assign data3InvSig = ~data3In;
    assign data4TrueSig = data4In;
    assign data4InvSig = ~data4In;

    // A cleared bit forces its term to zero, so it cannot reach the OR
    assign termMask[`LCG3_BIT_D4T] = sel.g3TakeData4True & data4TrueSig;
    assign termMask[`LCG3_BIT_D4N] = sel.g3TakeData4Inv & data4InvSig;
    assign termMask[`LCG3_BIT_D3T] = sel.g3TakeData3True & data3TrueSig;
    assign termMask[`LCG3_BIT_D3N] = sel.g3TakeData3Inv & data3InvSig;
    assign termMask[`LCG3_BIT_D2T] = sel.g3TakeData2True & data2TrueSig;
    assign termMask[`LCG3_BIT_D2N] = sel.g3TakeData2Inv & data2InvSig;
    assign termMask[`LCG3_BIT_D1T] = sel.g3TakeData1True & data1TrueSig;
    assign termMask[`LCG3_BIT_D1N] = sel.g3TakeData1Inv & data1InvSig;

    // With nothing selected the gate input rests low
    assign gateThreeInput = |termMask;

endmodule

`default_nettype wire

// *** core/lcg3_select.sv ***
// Gate-three input selector with its APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "lcg3_cfg.svh"

module lcg3_select (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`LCG3_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data selector outputs
    input wire logic data1In,
    input wire logic data2In,
    input wire logic data3In,
    input wire logic data4In,
    // Gate three
    output logic gateThreeInput,
    output logic [7:0] gateThreeTerms,
    output lcg3_pkg::lcg3_select_t gateThreeSelect
);
    import lcg3_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        lcg3_select_t sel;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic gate;
        logic [7:0] terms;
    } lcg3_state_t;

    lcg3_state_t state_q;
    lcg3_state_t state_d;

    logic [7:0] termMaskNow;
    logic gateNow;

    // ==========================================================
    // Helpers
    function automatic lcg3_reg_t decodeReg(input logic [`LCG3_ADDR_W-1:0] addr);
        lcg3_reg_t r;
        r = LCG3_REG_NONE;
        if (addr == `LCG3_OFF_SELECT) begin
            r = LCG3_REG_SELECT;
        end else if (addr == `LCG3_OFF_STATUS) begin
            r = LCG3_REG_STATUS;
        end
        return r;
    endfunction

    function automatic logic [31:0] readWord(
        input lcg3_reg_t r,
        input lcg3_select_t sel,
        input logic [7:0] terms,
        input logic gate
    );
        logic [31:0] w;
        w = `LCG3_RST_WORD;
        unique case (r)
            LCG3_REG_SELECT: begin
                w[7:0] = sel;
            end
            LCG3_REG_STATUS: begin
                w[`LCG3_STAT_TERM_LSB +: 8] = terms;
                w[`LCG3_STAT_GATE_BIT] = gate;
            end
            LCG3_REG_NONE: begin
                w = `LCG3_RST_WORD;
            end
        endcase
        return w;
    endfunction

    // ==========================================================
    // Gating network
    lcg3_gate_mux u_mux (
        .sel(state_q.sel),
        .data1In(data1In),
        .data2In(data2In),
        .data3In(data3In),
        .data4In(data4In),
        .termMask(termMaskNow),
        .gateThreeInput(gateNow)
    );

    // ==========================================================
    // Next state
    always_comb begin
        lcg3_reg_t which;
        logic setup;
        logic access;
        which = decodeReg(paddr);
        setup = psel & ~penable;
        access = psel & penable & state_q.ready;
        state_d = state_q;

        // Outputs follow the gating one clock later, so they are glitch free
        state_d.terms = termMaskNow;
        state_d.gate = gateNow;

        // Answer is prepared in the setup cycle so that pready is a flop
        if (setup) begin
            state_d.ready = 1'b1;
            state_d.err = (which == LCG3_REG_NONE);
            state_d.rdata = pwrite ? `LCG3_RST_WORD
                : readWord(which, state_q.sel, state_q.terms, state_q.gate);
        end else if (access) begin
            state_d.ready = 1'b0;
            state_d.err = 1'b0;
            state_d.rdata = `LCG3_RST_WORD;
        end

        // Write lands only on the completing edge; lane 0 holds all eight bits
        if (access && pwrite && which == LCG3_REG_SELECT && pstrb[0]) begin
            state_d.sel = lcg3_select_t'(pwdata[7:0]);
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q.sel <= lcg3_select_t'(`LCG3_RST_SELECT);
            state_q.rdata <= `LCG3_RST_WORD;
            state_q.ready <= 1'b0;
            state_q.err <= 1'b0;
            state_q.gate <= 1'b0;
            state_q.terms <= 8'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = state_q.rdata;
    assign pready = state_q.ready;
    assign pslverr = state_q.err;
    assign gateThreeInput = state_q.gate;
    assign gateThreeTerms = state_q.terms;
    assign gateThreeSelect = state_q.sel;

endmodule

`default_nettype wire

// *** testbench/lcg3_select_sva.sv ***
// Assertion checker for the gate-three input selector
`timescale 1ns/1ps
`default_nettype none
module lcg3_select_sva
    import lcg3_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Gate three
    input wire logic data1In,
    input wire logic data2In,
    input wire logic data3In,
    input wire logic data4In,
    input wire logic gateThreeInput,
    input wire logic [7:0] gateThreeTerms,
    input wire lcg3_pkg::lcg3_select_t gateThreeSelect
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==========================================================
    // Terms follow select and data of the previous edge
    chk_d4_true: assert property (gateThreeTerms[7] == $past(gateThreeSelect[7] & data4In))
        else $error("data four true term wrong");
    chk_d4_inv: assert property (gateThreeTerms[6] == $past(gateThreeSelect[6] & !data4In))
        else $error("data four inverted term wrong");
    chk_d2_inv: assert property (gateThreeTerms[2] == $past(gateThreeSelect[2] & !data2In))
        else $error("data two inverted term wrong");
    chk_d1_true: assert property (gateThreeTerms[1] == $past(gateThreeSelect[1] & data1In))
        else $error("data one true term wrong");
    chk_d1_inv: assert property (gateThreeTerms[0] == $past(gateThreeSelect[0] & !data1In))
        else $error("data one inverted term wrong");
    chk_mid_terms: assert property (gateThreeTerms[5:3] == $past(gateThreeSelect[5:3]
        & {data3In, !data3In, data2In}))
        else $error("middle terms wrong");
    chk_gate_or: assert property (gateThreeInput == |gateThreeTerms)
        else $error("gate input is not the OR of its terms");
    // ==========================================================
    // Access phase is exactly one cycle
    chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    cover property (pslverr);
    cover property (gateThreeInput);
    cover property ($rose(gateThreeSelect[7]));
endmodule
bind lcg3_select lcg3_select_sva u_lcg3_select_sva (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .data1In(data1In),
    .data2In(data2In), .data3In(data3In), .data4In(data4In), .gateThreeInput(gateThreeInput),
    .gateThreeTerms(gateThreeTerms), .gateThreeSelect(gateThreeSelect));
`default_nettype wire

// *** testbench/lcg3_select_tb.sv ***
// Self-checking bench for the gate-three input selector
`timescale 1ns/1ps
`default_nettype none
module lcg3_select_tb;
    import lcg3_pkg::*;
    logic clk_sys = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic data1In = 1'h0, data2In = 1'h0, data3In = 1'h0, data4In = 1'h0;
    logic pready, pslverr, gateThreeInput;
    logic [7:0] gateThreeTerms, v, selM = 8'h00, expT = 8'h00, statT = 8'h00;
    lcg3_select_t gateThreeSelect;
    int errors = 0, samples_checked = 0;
    lcg3_select u_lcg3_select (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .data1In, .data2In, .data3In, .data4In,
        .gateThreeInput, .gateThreeTerms, .gateThreeSelect);
    initial forever #2.5 clk_sys = ~clk_sys;
    // ==========================================================
    // Reporting
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        input logic [3:0] st);
        int n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            errors++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        if (w && a == 12'h000 && st[0]) selM = wd[7:0];
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    // ==========================================================
    // Random data inputs and the cycle-by-cycle model
    always @(negedge clk_sys) begin
        if (!reset) begin
            chk("terms", 32'(gateThreeTerms), 32'(expT));
            chk("gate", 32'(gateThreeInput), 32'(|expT));
            chk("select", 32'(gateThreeSelect), 32'(selM));
        end
        // Status is read from the terms standing at the setup edge
        if (psel && !penable) statT = expT;
        expT = selM & {data4In, ~data4In, data3In, ~data3In, data2In, ~data2In, data1In, ~data1In};
    end
    initial begin
        void'($urandom(41965));
        // Forked after seeding, so the data stream follows the seed as well
        fork
            forever begin
                @(posedge clk_sys);
                {data4In, data3In, data2In, data1In} <= 4'($urandom);
            end
        join_none
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        apb(1'h0, 12'h000, 32'h0, 4'h0);
        chk("reset value", rd, 32'h0);
        // Each bit alone, then all, then random masks
        for (int i = 0; i < 26; i++) begin
            v = (i < 8) ? 8'h01 << i : (i == 8) ? 8'hff : 8'($urandom);
            apb(1'h1, 12'h000, {24'($urandom), v}, 4'hf);
            repeat (6) @(posedge clk_sys);
            apb(1'h0, 12'h000, 32'h0, 4'h0);
            chk("readback", rd, {24'h0, selM});
            apb(1'h0, 12'h004, 32'h0, 4'h0);
            chk("status", rd, {23'h0, |statT, statT});
        end
        // Low strobe and unmapped address must not change select
        apb(1'h1, 12'h000, 32'h0, 4'he);
        apb(1'h1, 12'h008, 32'h0, 4'hf);
        chk("unmapped write err", 32'(er), 32'h1);
        apb(1'h0, 12'h008, 32'h0, 4'h0);
        chk("unmapped read err", 32'(er), 32'h1);
        chk("unmapped read data", rd, 32'h0);
        apb(1'h0, 12'h000, 32'h0, 4'h0);
        chk("select kept", rd, {24'h0, selM});
        close_out();
    end
endmodule
`default_nettype wire
